// >>> common/vector_unit_pkg.sv
// shared constants and carriers for the vector address unit
package vector_unit_pkg;
  localparam int unsigned ADDR_W = 20;
  localparam int unsigned APB_AW = 12;
  localparam int unsigned PIN_COUNT = 6;
  localparam int unsigned HW_COUNT = 32;
  localparam int unsigned LEVEL_W = 3;
  localparam int unsigned ENTRY_BYTES = 4;
  localparam int unsigned VAR_TABLE_BYTES = 256;
  // ------------------------------------------------------------
  // fixed vector table
  // ------------------------------------------------------------
  localparam logic [19:0] FIXED_TABLE_LO = 20'hfffdc;
  localparam logic [19:0] FIXED_TABLE_HI = 20'hfffff;
  localparam logic [19:0] VEC_UNDEFINED = 20'hfffdc;
  localparam logic [19:0] VEC_OVERFLOW = 20'hfffe0;
  localparam logic [19:0] VEC_BREAK = 20'hfffe4;
  localparam logic [19:0] VEC_ADDR_MATCH = 20'hfffe8;
  localparam logic [19:0] VEC_SINGLE_STEP = 20'hfffec;
  localparam logic [19:0] VEC_WATCHDOG = 20'hffff0;
  localparam logic [19:0] VEC_DEBUGGER = 20'hffff4;
  localparam logic [19:0] VEC_NMI = 20'hffff8;
  localparam logic [19:0] VEC_RESET = 20'hffffc;
  localparam logic [7:0] BREAK_REDIRECT_BYTE = 8'hff;
  // ------------------------------------------------------------
  // special sources, lowest index wins
  // ------------------------------------------------------------
  localparam int SP_RESET = 0;
  localparam int SP_NMI = 1;
  localparam int SP_DEBUGGER = 2;
  localparam int SP_WATCHDOG = 3;
  localparam int SP_STEP = 4;
  localparam int SP_MATCH = 5;
  localparam int SP_UNDEF = 6;
  localparam int SP_OVERFLOW = 7;
  localparam int SP_BREAK = 8;
  localparam int SP_SOFT = 9;
  localparam int SP_COUNT = 10;
  localparam logic [9:0] SPECIAL_RESET = 10'h001;
  // ------------------------------------------------------------
  // register map
  // ------------------------------------------------------------
  localparam logic [11:0] OFF_BASE = 12'h000;
  localparam logic [11:0] OFF_CONFIG = 12'h004;
  localparam logic [11:0] OFF_PIN_CONFIG = 12'h008;
  localparam logic [11:0] OFF_PENDING = 12'h00c;
  localparam logic [11:0] OFF_LEVEL0 = 12'h010;
  localparam logic [11:0] OFF_STATUS = 12'h020;
  localparam logic [11:0] OFF_LAST_HANDLER = 12'h024;
  localparam int LEVEL_REGS = 4;
  localparam int CFG_MATCH_EN_BIT = 0;
  localparam int CFG_TWO_WIRE_BIT = 1;
  localparam int CFG_CAUSE8_BIT = 6;
  localparam int CFG_CAUSE9_BIT = 7;
  localparam int PINCFG_RISE_LSB = 0;
  localparam int PINCFG_BOTH_LSB = 8;
  localparam logic [19:0] BASE_RESET = 20'h00000;
  localparam logic [7:0] CONFIG_RESET = 8'h00;
  localparam logic [5:0] PINCFG_RESET = 6'h00;

  typedef struct packed {
    logic [5:0] timer_b;
    logic [4:0] timer_a;
    logic [2:0] uart_tx;
    logic [2:0] uart_rx;
    logic [1:0] sync_serial;
    logic two_wire_nack;
    logic two_wire_ack;
    logic bus_collision;
    logic [1:0] dma;
    logic key_input;
    logic adc_done;
  } periph_events_t;

  typedef struct packed {
    logic undefined_opcode_trap;
    logic overflow_trap;
    logic overflow_flag;
    logic break_opcode;
    logic soft_int_req;
    logic [5:0] soft_int_num;
    logic single_step;
    logic debugger_break;
    logic watchdog;
    logic address_match;
  } core_traps_t;
endpackage

// >>> hw/level_arbiter.sv
// picks the eligible maskable request of highest level
`timescale 1ns/1ps
module level_arbiter
  import vector_unit_pkg::*;
#(
  parameter int unsigned NUM = 32
) (
  input wire logic [NUM-1:0] pend,
  input wire logic [NUM*LEVEL_W-1:0] levels,
  input wire logic [LEVEL_W-1:0] threshold,
  input wire logic enable,
  output logic valid,
  output logic [4:0] number
);
  logic [LEVEL_W-1:0] best;
  logic found;

  always_comb begin
    best = threshold;
    found = 1'b0;
    number = 5'h00;
    // strict compare keeps the lowest number on a tie
    for (int i = 0; i < NUM; i++) begin
      if (pend[i] && (levels[i*LEVEL_W +: LEVEL_W] > best)) begin
        best = levels[i*LEVEL_W +: LEVEL_W];
        found = 1'b1;
        number = 5'(i);
      end
    end
    valid = found && enable;
  end
endmodule

// >>> hw/pin_edge_detect.sv
// synchronised edge detector for one external request pin
`timescale 1ns/1ps
module pin_edge_detect
  import vector_unit_pkg::*;
#(
  parameter logic IDLE_LEVEL = 1'b1
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic pin,
  input wire logic rise_sel,
  input wire logic both_sel,
  output logic edge_pulse
);
  logic s1;
  logic s2;
  logic s3;
  logic stable;
  logic change;

  // s1 feeds only s2
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s1 <= IDLE_LEVEL;
      s2 <= IDLE_LEVEL;
      s3 <= IDLE_LEVEL;
    end else begin
      s1 <= pin;
      s2 <= s1;
      s3 <= s2;
    end
  end

  assign change = (s2 == s3) && (s3 != stable);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stable <= IDLE_LEVEL;
      edge_pulse <= 1'b0;
    end else begin
      if (change) begin
        stable <= s3;
      end
      // clear polarity picks falling, set picks rising
      edge_pulse <= change && (both_sel || (rise_sel == s3));
    end
  end
endmodule

// >>> hw/vector_address_unit.sv
// interrupt vector address unit with apb registers and vector fetch
//
// The implementer's own choices: the register offsets and register access over APB.
`timescale 1ns/1ps
// Function
// - fixed table spans fffdc to fffff, four bytes per handler entry
// - undefined trap uses fffdc; overflow trap with flag set uses fffe0
// - break uses fffe4; byte ff there redirects to variable entry zero
// - address match uses fffe8, gated by its own enable bit
// - single step and debugger break vectors reserved for debug tools
// - watchdog ffff0, nmi pin ffff8, reset ffffc
// - variable table is 256 bytes from the base register
// - variable entry address is base plus four times the number
// - number zero is break, never masked by global enable
// - numbers 4 to 7: pin 3, timer b5, b4, b3
// - numbers 8 and 9 pick serial or pin source by cause bits
// - numbers 10 to 14: collision, dma0, dma1, key, adc
// - numbers 15, 16: uart2 tx, rx, or nack, ack in two-wire mode
// - numbers 17 to 20: uart0 tx, rx, uart1 tx, rx
// - numbers 21 to 25: timer a0 to a4
// - numbers 26 to 28: timer b0 to b2
// - numbers 29 to 31: pins 0 to 2
// - numbers 32 to 63 software only, ignore global enable
// - pins trigger on rising, falling or both edges as configured
// - on acceptance branch to the handler read from the entry
// - polarity clear selects falling, set selects rising
// - maskable accepted only with enable, request, level above threshold
module vector_address_unit
  import vector_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [APB_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire periph_events_t periph_events,
  input wire core_traps_t core_traps,
  input wire logic [PIN_COUNT-1:0] external_request_pin,
  input wire logic nmi_pin_n,
  input wire logic irq_enable_flag,
  input wire logic [LEVEL_W-1:0] cpu_priority_threshold,
  output logic mem_req,
  output logic [ADDR_W-1:0] mem_addr,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ack,
  output logic vector_busy,
  output logic handler_valid,
  output logic [ADDR_W-1:0] handler_addr,
  output logic [ADDR_W-1:0] vector_addr,
  output logic [5:0] accepted_number,
  output logic accepted_fixed
);
  typedef enum logic [0:0] {ST_IDLE, ST_FETCH} state_t;

  state_t state;
  logic [ADDR_W-1:0] vector_table_base;
  logic [7:0] cfg;
  logic [PIN_COUNT-1:0] pin_rise;
  logic [PIN_COUNT-1:0] pin_both;
  logic [HW_COUNT*LEVEL_W-1:0] levels;
  logic [HW_COUNT-1:0] pend;
  logic [SP_COUNT-1:0] special_pend;
  logic [5:0] soft_num;
  logic [PIN_COUNT-1:0] pin_edge;
  logic nmi_edge;
  logic [HW_COUNT-1:0] hw_set;
  logic mask_valid;
  logic [4:0] mask_number;
  logic [1:0] byte_idx;
  logic break_check;
  logic [15:0] low_bytes;
  logic [31:0] read_word;
  logic apb_setup;
  logic wr_fire;
  logic [31:0] sw_clear;
  logic accept;
  logic sel_valid;
  logic sel_special;
  logic [3:0] sel_idx;
  logic [5:0] sel_number;
  logic [ADDR_W-1:0] sel_addr;
  logic [SP_COUNT-1:0] special_set;
  logic [SP_COUNT-1:0] special_clr;
  logic [HW_COUNT-1:0] pend_clr;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  function automatic logic reg_hit(input logic [APB_AW-1:0] a);
    logic hit;
    hit = (a == OFF_BASE) || (a == OFF_CONFIG) || (a == OFF_PIN_CONFIG);
    hit = hit || (a == OFF_PENDING) || (a == OFF_STATUS);
    hit = hit || (a == OFF_LAST_HANDLER);
    hit = hit || ((a[11:4] == OFF_LEVEL0[11:4]) && (a[1:0] == 2'b00));
    return hit;
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] strb);
    logic [31:0] m;
    m = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        m[b*8 +: 8] = wd[b*8 +: 8];
      end
    end
    return m;
  endfunction

  function automatic logic [ADDR_W-1:0] var_entry(input logic [ADDR_W-1:0] base,
                                                  input logic [5:0] num);
    // wraps within the 20-bit space
    return ADDR_W'(base + ADDR_W'(num) * ADDR_W'(ENTRY_BYTES));
  endfunction

  function automatic logic [ADDR_W-1:0] fixed_vector(input logic [3:0] idx);
    logic [ADDR_W-1:0] v;
    unique case (idx)
      4'(SP_RESET): v = VEC_RESET;
      4'(SP_NMI): v = VEC_NMI;
      4'(SP_DEBUGGER): v = VEC_DEBUGGER;
      4'(SP_WATCHDOG): v = VEC_WATCHDOG;
      4'(SP_STEP): v = VEC_SINGLE_STEP;
      4'(SP_MATCH): v = VEC_ADDR_MATCH;
      4'(SP_UNDEF): v = VEC_UNDEFINED;
      4'(SP_OVERFLOW): v = VEC_OVERFLOW;
      4'(SP_BREAK): v = VEC_BREAK;
      default: v = FIXED_TABLE_LO;
    endcase
    return v;
  endfunction

  function automatic logic [31:0] map_sources(input periph_events_t ev,
                                              input logic [PIN_COUNT-1:0] pe,
                                              input logic [7:0] c);
    logic [31:0] m;
    m = '0;
    m[4] = pe[3];
    m[5] = ev.timer_b[5];
    m[6] = ev.timer_b[4];
    m[7] = ev.timer_b[3];
    m[8] = c[CFG_CAUSE8_BIT] ? pe[5] : ev.sync_serial[1];
    m[9] = c[CFG_CAUSE9_BIT] ? pe[4] : ev.sync_serial[0];
    m[10] = ev.bus_collision;
    m[11] = ev.dma[0];
    m[12] = ev.dma[1];
    m[13] = ev.key_input;
    m[14] = ev.adc_done;
    m[15] = c[CFG_TWO_WIRE_BIT] ? ev.two_wire_nack : ev.uart_tx[2];
    m[16] = c[CFG_TWO_WIRE_BIT] ? ev.two_wire_ack : ev.uart_rx[2];
    m[17] = ev.uart_tx[0];
    m[18] = ev.uart_rx[0];
    m[19] = ev.uart_tx[1];
    m[20] = ev.uart_rx[1];
    for (int i = 0; i < 5; i++) begin
      m[21+i] = ev.timer_a[i];
    end
    for (int i = 0; i < 3; i++) begin
      m[26+i] = ev.timer_b[i];
      m[29+i] = pe[i];
    end
    return m;
  endfunction

  // ------------------------------------------------------------
  // request pins
  // ------------------------------------------------------------
  for (genvar g = 0; g < PIN_COUNT; g++) begin : g_pin
    pin_edge_detect #(.IDLE_LEVEL(1'b1)) u_edge (
      .pclk(pclk),
      .presetn(presetn),
      .pin(external_request_pin[g]),
      .rise_sel(pin_rise[g]),
      .both_sel(pin_both[g]),
      .edge_pulse(pin_edge[g])
    );
  end

  // nmi acts on the pin going low
  pin_edge_detect #(.IDLE_LEVEL(1'b1)) u_nmi_edge (
    .pclk(pclk),
    .presetn(presetn),
    .pin(nmi_pin_n),
    .rise_sel(1'b0),
    .both_sel(1'b0),
    .edge_pulse(nmi_edge)
  );

  level_arbiter #(.NUM(HW_COUNT)) u_arbiter (
    .pend(pend),
    .levels(levels),
    .threshold(cpu_priority_threshold),
    .enable(irq_enable_flag),
    .valid(mask_valid),
    .number(mask_number)
  );

  assign hw_set = map_sources(periph_events, pin_edge, cfg);

  // ------------------------------------------------------------
  // apb slave, zero wait states
  // ------------------------------------------------------------
  assign apb_setup = psel && !penable;
  assign wr_fire = psel && penable && pwrite && reg_hit(paddr);
  assign pready = 1'b1;
  assign pslverr = psel && penable && !reg_hit(paddr);

  always_comb begin
    read_word = 32'h0;
    if (paddr == OFF_BASE) begin
      read_word[ADDR_W-1:0] = vector_table_base;
    end else if (paddr == OFF_CONFIG) begin
      read_word[7:0] = cfg;
    end else if (paddr == OFF_PIN_CONFIG) begin
      read_word[PINCFG_RISE_LSB +: PIN_COUNT] = pin_rise;
      read_word[PINCFG_BOTH_LSB +: PIN_COUNT] = pin_both;
    end else if (paddr == OFF_PENDING) begin
      read_word = pend;
    end else if (paddr == OFF_STATUS) begin
      read_word[0] = vector_busy;
      read_word[13:8] = accepted_number;
      read_word[16] = accepted_fixed;
      read_word[31:22] = special_pend;
    end else if (paddr == OFF_LAST_HANDLER) begin
      read_word[ADDR_W-1:0] = handler_addr;
    end else if (reg_hit(paddr)) begin
      for (int k = 0; k < 8; k++) begin
        read_word[k*4 +: LEVEL_W] = levels[(paddr[3:2]*8+k)*LEVEL_W +: LEVEL_W];
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (apb_setup) begin
      prdata <= pwrite ? 32'h0 : read_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      vector_table_base <= BASE_RESET;
      cfg <= CONFIG_RESET;
      pin_rise <= PINCFG_RESET;
      pin_both <= PINCFG_RESET;
    end else if (wr_fire) begin
      if (paddr == OFF_BASE) begin
        vector_table_base <= ADDR_W'(merge(32'(vector_table_base), pwdata, pstrb));
      end else if (paddr == OFF_CONFIG) begin
        cfg <= 8'(merge(32'(cfg), pwdata, pstrb));
      end else if ((paddr == OFF_PIN_CONFIG) && pstrb[0]) begin
        pin_rise <= pwdata[PINCFG_RISE_LSB +: PIN_COUNT];
      end
      if ((paddr == OFF_PIN_CONFIG) && pstrb[1]) begin
        pin_both <= pwdata[PINCFG_BOTH_LSB +: PIN_COUNT];
      end
    end
  end

  // priority levels, one nibble per source
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      levels <= '0;
    end else if (wr_fire && (paddr[11:4] == OFF_LEVEL0[11:4])) begin
      for (int k = 0; k < 8; k++) begin
        if (pstrb[k/2]) begin
          levels[(paddr[3:2]*8+k)*LEVEL_W +: LEVEL_W] <= pwdata[k*4 +: LEVEL_W];
        end
      end
    end
  end

  // ------------------------------------------------------------
  // pending requests, set beats clear
  // ------------------------------------------------------------
  always_comb begin
    sw_clear = 32'h0;
    if (wr_fire && (paddr == OFF_PENDING)) begin
      for (int b = 0; b < 4; b++) begin
        if (pstrb[b]) begin
          sw_clear[b*8 +: 8] = ~pwdata[b*8 +: 8];
        end
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pend <= '0;
    end else begin
      pend <= (pend & ~sw_clear & ~pend_clr) | hw_set;
    end
  end

  // debug sources come only from the core_traps inputs
  always_comb begin
    special_set = '0;
    special_set[SP_NMI] = nmi_edge;
    special_set[SP_DEBUGGER] = core_traps.debugger_break;
    special_set[SP_WATCHDOG] = core_traps.watchdog;
    special_set[SP_STEP] = core_traps.single_step;
    special_set[SP_MATCH] = core_traps.address_match && cfg[CFG_MATCH_EN_BIT];
    special_set[SP_UNDEF] = core_traps.undefined_opcode_trap;
    special_set[SP_OVERFLOW] = core_traps.overflow_trap && core_traps.overflow_flag;
    special_set[SP_BREAK] = core_traps.break_opcode;
    special_set[SP_SOFT] = core_traps.soft_int_req;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      special_pend <= SPECIAL_RESET;
      soft_num <= 6'h00;
    end else begin
      special_pend <= (special_pend & ~special_clr) | special_set;
      // a second software request while one is pending is lost; soft_num keeps the first number
      if (special_set[SP_SOFT] && (!special_pend[SP_SOFT] || special_clr[SP_SOFT])) begin
        soft_num <= core_traps.soft_int_num;
      end
    end
  end

  // ------------------------------------------------------------
  // selection: specials by index, then maskable by level
  // ------------------------------------------------------------
  always_comb begin
    sel_valid = 1'b0;
    sel_special = 1'b0;
    sel_idx = 4'h0;
    for (int i = SP_COUNT - 1; i >= 0; i--) begin
      if (special_pend[i]) begin
        sel_valid = 1'b1;
        sel_special = 1'b1;
        sel_idx = 4'(i);
      end
    end
    if (!sel_valid && mask_valid) begin
      sel_valid = 1'b1;
    end
    // software numbers bypass the global enable
    sel_number = sel_special ? soft_num : {1'b0, mask_number};
    if (sel_special && (sel_idx != 4'(SP_SOFT))) begin
      sel_addr = fixed_vector(sel_idx);
    end else begin
      sel_addr = var_entry(vector_table_base, sel_number);
    end
  end

  assign accept = (state == ST_IDLE) && sel_valid;

  always_comb begin
    special_clr = '0;
    pend_clr = '0;
    if (accept && sel_special) begin
      special_clr[sel_idx] = 1'b1;
    end else if (accept) begin
      pend_clr[mask_number] = 1'b1;
    end
  end

  // ------------------------------------------------------------
  // vector fetch
  // ------------------------------------------------------------
  assign mem_req = (state == ST_FETCH);
  assign vector_busy = (state == ST_FETCH);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      mem_addr <= VEC_RESET;
      vector_addr <= VEC_RESET;
      byte_idx <= 2'd0;
      break_check <= 1'b0;
      low_bytes <= 16'h0;
      accepted_number <= 6'h00;
      accepted_fixed <= 1'b0;
    end else begin
      unique case (state)
        ST_IDLE: begin
          if (accept) begin
            state <= ST_FETCH;
            mem_addr <= sel_addr;
            vector_addr <= sel_addr;
            byte_idx <= 2'd0;
            break_check <= sel_special && (sel_idx == 4'(SP_BREAK));
            accepted_fixed <= sel_special && (sel_idx != 4'(SP_SOFT));
            accepted_number <= sel_number;
          end
        end
        ST_FETCH: begin
          if (mem_ack && break_check && (mem_rdata == BREAK_REDIRECT_BYTE)) begin
            mem_addr <= var_entry(vector_table_base, 6'h00);
            vector_addr <= var_entry(vector_table_base, 6'h00);
            break_check <= 1'b0;
            accepted_fixed <= 1'b0;
          end else if (mem_ack) begin
            // bytes arrive lowest address first; top byte never read
            break_check <= 1'b0;
            if (byte_idx == 2'd0) begin
              low_bytes[7:0] <= mem_rdata;
            end else if (byte_idx == 2'd1) begin
              low_bytes[15:8] <= mem_rdata;
            end
            if (byte_idx == 2'd2) begin
              state <= ST_IDLE;
            end
            byte_idx <= byte_idx + 2'd1;
            mem_addr <= ADDR_W'(mem_addr + ADDR_W'(1));
          end
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      handler_valid <= 1'b0;
      handler_addr <= '0;
    end else begin
      handler_valid <= 1'b0;
      if ((state == ST_FETCH) && mem_ack && (byte_idx == 2'd2) && !break_check) begin
        handler_valid <= 1'b1;
        handler_addr <= {mem_rdata[3:0], low_bytes};
      end
    end
  end
endmodule

// >>> testbench/interrupt_vector_address_unit_tb_top.sv
// self-checking bench for the vector address unit
`timescale 1ns/1ps
module interrupt_vector_address_unit_tb_top;
  import vector_unit_pkg::*;
  typedef struct packed {logic f; logic [5:0] n; logic [19:0] v; logic [19:0] a;} exp_t;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic pready, pslverr, mem_req, mem_ack, vector_busy, handler_valid, accepted_fixed;
  logic slow = 1'b0, nmi_pin_n = 1'b1, irq_enable_flag = 1'b0, err;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic [3:0] pstrb = 4'hf;
  logic [19:0] mem_addr, handler_addr, vector_addr, base = 20'h0;
  logic [7:0] mem_rdata;
  logic [5:0] accepted_number, external_request_pin = 6'h3f;
  logic [2:0] cpu_priority_threshold = 3'h0;
  periph_events_t periph_events = '0;
  core_traps_t core_traps = '0;
  exp_t exp_q[$];
  exp_t e;
  int failures = 0, checks = 0, seed = 32'hfc8f071c, n, k;
  int nt[26] = '{14, 13, 11, 12, 10, 16, 15, 9, 8, 18, 20, 16, 17, 19, 15,
                 21, 22, 23, 24, 25, 26, 27, 28, 7, 6, 5};
  int pn[6] = '{29, 30, 31, 4, 9, 8};
  always #4 pclk = ~pclk;
  vector_address_unit uut (.*);
  vector_mem_model mem (.*);
  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] ex);
    checks++;
    if (seen !== ex) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, ex, seen);
    end
  endtask
  task automatic complete_run;
    if (failures == 0 && checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  function automatic exp_t vx(input int num);
    logic [19:0] v;
    v = base + 20'(4 * num);
    return {1'b0, 6'(num), v, v};
  endfunction
  function automatic exp_t fx(input logic [19:0] v);
    return {1'b1, 6'h0, v, v};
  endfunction
  function automatic logic [19:0] hv(input logic [19:0] a);
    logic [7:0] b2;
    b2 = mem.rd(int'(a + 20'h2));
    return {b2[3:0], mem.rd(int'(a + 20'h1)), mem.rd(int'(a))};
  endfunction
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // the extra wait lets a spurious fetch show up
  task automatic drain;
    int i;
    for (i = 0; i < 300 && exp_q.size() > 0; i++) @(posedge pclk);
    repeat (20) @(posedge pclk);
    check("pending fetches", exp_q.size(), 0);
  endtask
  task automatic trap(input logic [14:0] t, input exp_t x);
    @(posedge pclk);
    core_traps <= core_traps_t'(t);
    if (x.a != 0) exp_q.push_back(x);
    @(posedge pclk);
    core_traps <= '0;
    drain();
  endtask
  task automatic ev(input logic [25:0] m, input int num);
    @(posedge pclk);
    periph_events <= periph_events_t'(m);
    if (num >= 0) exp_q.push_back(vx(num));
    @(posedge pclk);
    periph_events <= '0;
    drain();
  endtask
  task automatic pin(input int p, input logic lv, input int num);
    @(posedge pclk);
    external_request_pin[p] <= lv;
    if (num >= 0) exp_q.push_back(vx(num));
    drain();
  endtask
  always @(posedge pclk) begin
    if (presetn && handler_valid === 1'b1) begin
      if (exp_q.size() == 0) check("spurious handler", 1, 0);
      else begin
        e = exp_q.pop_front();
        check("handler", handler_addr, hv(e.a));
        check("fixed", accepted_fixed, e.f);
        if (e.a == e.v) check("vector", vector_addr, e.v);
        if (!e.f && e.a == e.v) check("number", accepted_number, e.n);
      end
    end
  end
  initial begin
    repeat (30000) @(posedge pclk);
    failures++;
    complete_run();
  end
  initial begin
    exp_q.push_back(fx(VEC_RESET));
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_BASE, 32'h0);
    check("base reset", rd, 32'(BASE_RESET));
    apb(1'b0, 12'h100, 32'h0);
    check("unmapped", err, 1'b1);
    drain();
    base = 20'($random(seed)) & 20'hffffc;
    slow <= 1'b1;
    apb(1'b1, OFF_BASE, 32'(base));
    apb(1'b1, OFF_CONFIG, 32'h1);
    for (n = 0; n < LEVEL_REGS; n++) apb(1'b1, OFF_LEVEL0 + 12'(4 * n), 32'h11111111);
    // debug-only sources stay unused by application stimulus
    trap(15'h4000, fx(VEC_UNDEFINED));
    trap(15'h2000, '0);
    trap(15'h3000, fx(VEC_OVERFLOW));
    trap(15'h0800, fx(VEC_BREAK));
    trap(15'h0002, fx(VEC_WATCHDOG));
    trap(15'h0001, fx(VEC_ADDR_MATCH));
    apb(1'b1, OFF_CONFIG, 32'h0);
    trap(15'h0001, '0);
    mem.m[int'(VEC_BREAK)] = 8'hff;
    trap(15'h0800, {1'b0, 6'h0, 20'h0, base});
    mem.m.delete();
    for (n = 0; n < 6; n++) begin
      k = (n == 0) ? 0 : 32 + ($random(seed) & 31);
      trap(15'h0400 | 15'(k << 4), vx(k));
    end
    nmi_pin_n <= 1'b0;
    exp_q.push_back(fx(VEC_NMI));
    drain();
    nmi_pin_n <= 1'b1;
    slow <= 1'b0;
    ev(26'h8000, -1);
    apb(1'b0, OFF_PENDING, 32'h0);
    check("pending", rd, 32'h1 << 21);
    irq_enable_flag <= 1'b1;
    cpu_priority_threshold <= 3'h1;
    ev(26'h0, -1);
    cpu_priority_threshold <= 3'h0;
    exp_q.push_back(vx(21));
    drain();
    exp_q.push_back(vx(14));
    exp_q.push_back(vx(21));
    ev(26'h8001, -1);
    for (n = 0; n < 26; n++) begin
      apb(1'b1, OFF_CONFIG, (n == 5 || n == 6) ? 32'h2 : 32'h0);
      ev(26'h1 << n, nt[n]);
    end
    apb(1'b1, OFF_CONFIG, 32'hc0);
    apb(1'b1, OFF_PIN_CONFIG, 32'h3f);
    for (n = 0; n < 6; n++) begin
      pin(n, 1'b0, -1);
      pin(n, 1'b1, pn[n]);
    end
    apb(1'b1, OFF_PIN_CONFIG, 32'h0);
    pin(0, 1'b0, 29);
    apb(1'b1, OFF_PIN_CONFIG, 32'h100);
    pin(0, 1'b1, 29);
    pin(0, 1'b0, 29);
    complete_run();
  end
endmodule

// >>> testbench/vector_address_unit_asserts.sv
// assertions on the vector fetch ports
`timescale 1ns/1ps
module vector_address_unit_asserts
  import vector_unit_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic mem_ack,
  input wire logic [ADDR_W-1:0] mem_addr,
  input wire logic vector_busy,
  input wire logic handler_valid,
  input wire logic [ADDR_W-1:0] vector_addr,
  input wire logic accepted_fixed
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic [3:0] acks;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acks <= 4'h0;
    end else if (handler_valid) begin
      acks <= 4'h0;
    end else if (mem_req && mem_ack) begin
      acks <= acks + 4'h1;
    end
  end
  property p_fixed_entry;
    accepted_fixed |-> vector_addr >= FIXED_TABLE_LO && vector_addr[1:0] == 2'b00;
  endproperty
  a_fixed_entry: assert property (p_fixed_entry) else $error("fixed entry off");
  property p_fetch_start;
    $rose(mem_req) |-> mem_addr == vector_addr;
  endproperty
  a_fetch_start: assert property (p_fetch_start) else $error("fetch start");
  property p_fetch_done;
    $rose(mem_req) |-> ##[3:100] handler_valid;
  endproperty
  a_fetch_done: assert property (p_fetch_done) else $error("no handler");
  property p_valid_pulse;
    handler_valid |=> !handler_valid;
  endproperty
  a_valid_pulse: assert property (p_valid_pulse) else $error("long valid");
  property p_idle_on_valid;
    handler_valid |-> !mem_req;
  endproperty
  a_idle_on_valid: assert property (p_idle_on_valid) else $error("req on valid");
  property p_fetch_end;
    $fell(mem_req) |-> handler_valid && !vector_busy;
  endproperty
  a_fetch_end: assert property (p_fetch_end) else $error("fetch end");
  property p_addr_hold;
    mem_req && !mem_ack |=> $stable(mem_addr);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("addr moved");
  property p_three_bytes;
    handler_valid |-> acks == 4'h3 || acks == 4'h4;
  endproperty
  a_three_bytes: assert property (p_three_bytes) else $error("byte count");
endmodule
bind vector_address_unit vector_address_unit_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .mem_req(mem_req), .mem_ack(mem_ack),
  .mem_addr(mem_addr), .vector_busy(vector_busy), .handler_valid(handler_valid),
  .vector_addr(vector_addr), .accepted_fixed(accepted_fixed));

// >>> testbench/vector_mem_model.sv
// byte memory answering vector reads, optionally stalling
`timescale 1ns/1ps
module vector_mem_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic mem_req,
  input wire logic [19:0] mem_addr,
  input wire logic slow,
  output logic [7:0] mem_rdata,
  output logic mem_ack
);
  logic [7:0] m [int];
  int stall;
  function automatic logic [7:0] rd(input int a);
    return m.exists(a) ? m[a] : 8'(a) ^ 8'ha5;
  endfunction
  // idle data toggles so a stale byte never looks valid
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mem_ack <= 1'b0;
      mem_rdata <= 8'h00;
      stall = 0;
    end else if (mem_req && !mem_ack && stall == 0) begin
      mem_ack <= 1'b1;
      mem_rdata <= rd(int'(mem_addr));
      stall = slow ? 2 : 0;
    end else begin
      mem_ack <= 1'b0;
      mem_rdata <= ~mem_rdata;
      if (stall > 0) stall = stall - 1;
    end
  end
endmodule
